// ### sdram_cfg_pkg.sv
// Purpose: shared constants and types of the sdram timing configuration
// Assumes: 32-bit apb data, one aligned word per register
// Notes: register offsets are full byte addresses
package sdram_cfg_pkg;

  localparam logic [31:0] SDRAM_CONFIG_ADDR = 32'hF0020000;
  localparam logic [31:0] SDRAM_COMMAND_ADDR = 32'hF0020004;
  localparam logic [31:0] REFRESH_PERIOD_ADDR = 32'hF0020008;
  localparam logic [31:0] WB_TIMEOUT_ADDR = 32'hF002000C;

  localparam logic [31:0] SDRAM_CONFIG_RESET = 32'h00099F0C;
  localparam logic [31:0] SDRAM_COMMAND_RESET = 32'h00000000;
  localparam logic [31:0] REFRESH_PERIOD_RESET = 32'h00000020;
  localparam logic [31:0] WB_TIMEOUT_RESET = 32'h00000000;

  // implemented width of the config, refresh and timeout registers, upper bits read as zero
  localparam int CFG_BITS = 20;
  localparam int REF_BITS = 16;
  localparam int WBTO_BITS = 16;

  // sdram_command field positions
  localparam int INIT_LSB = 0;
  localparam int INIT_BITS = 2;
  localparam int WBUF_BIT = 2;
  localparam int BUSY_BIT = 3;

  // init field codes
  localparam logic [1:0] INIT_NORMAL = 2'h0;
  localparam logic [1:0] INIT_PALL = 2'h1;
  localparam logic [1:0] INIT_MRS = 2'h2;

  // timing counter layout
  localparam int TCNT_BITS = 4;
  localparam int NUM_TCNT = 4;
  localparam int T_RCD = 0;
  localparam int T_RAS = 1;
  localparam int T_RC = 2;
  localparam int T_RP = 3;

  // sdram_config layout, msb first
  typedef struct packed {
    logic [3:0] row_active_time;
    logic [3:0] row_cycle_time;
    logic [1:0] row_to_column_delay;
    logic [1:0] precharge_time;
    logic [1:0] bank_group_zero_density;
    logic [1:0] bank_group_one_density;
    logic [1:0] cas_latency;
    logic auto_precharge_disable;
    logic bus_width_sel;
  } sdram_cfg_s;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_COL = 3'h2,
    CMD_PRE = 3'h3,
    CMD_PALL = 3'h4,
    CMD_MRS = 3'h5
  } cmd_kind_e;

  typedef struct packed {
    logic valid;
    cmd_kind_e kind;
    logic auto_pre;
  } cmd_s;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_PALL = 3'b010,
    ST_MRS = 3'b100
  } init_state_e;

endpackage

// ### sdram_timing_config.sv
// Purpose: apb register file and command pacing of the sdram controller
// Assumes: inputs synchronous to clock_i, zero-wait apb slave
// Notes:
// Operation
// - config bit 0 selects bus width, 0 is 32-bit, 1 is 16-bit
// - config bit 1 set disables auto precharge on reads and writes
// - config bits 3:2 give cas latency 1 to 3, 00 reserved, reset 11
// - bits 5:4 and 7:6 give bank group densities, reset 00
// - bits 9:8 give precharge time as code plus one cycles
// - bits 11:10 give activate-to-column delay as code plus one cycles
// - bits 15:12 give row cycle time as code plus one cycles
// - bits 19:16 give row active time as code plus one cycles
// - command register bit 3 reads busy, read-only, 0 when idle
`timescale 1ns/1ps

module sdram_timing_config
  import sdram_cfg_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [31:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic req_valid_i,
  input wire cmd_kind_e req_kind_i,
  output logic req_ready_o,
  output cmd_s cmd_o,
  output sdram_cfg_s cfg_o,
  output logic write_buffer_enable_o,
  output logic [REF_BITS-1:0] refresh_period_o,
  output logic [WBTO_BITS-1:0] wb_timeout_o,
  output logic busy_o
);

  sdram_cfg_s cfg;
  logic [INIT_BITS-1:0] init_mode;
  logic wbuf_en;
  logic [REF_BITS-1:0] refresh_period;
  logic [WBTO_BITS-1:0] write_buffer_timeout;
  init_state_e state;
  init_state_e next_state;
  cmd_s next_cmd;
  logic row_open;
  logic [TCNT_BITS-1:0] tcnt [NUM_TCNT];
  logic [TCNT_BITS-1:0] tload [NUM_TCNT];
  logic [NUM_TCNT-1:0] tstart;

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] din,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = din[8*i +: 8];
      end
    end
    return r;
  endfunction

  // apb decode
  wire sel_cfg = paddr_i == SDRAM_CONFIG_ADDR;
  wire sel_cmd = paddr_i == SDRAM_COMMAND_ADDR;
  wire sel_ref = paddr_i == REFRESH_PERIOD_ADDR;
  wire sel_wbto = paddr_i == WB_TIMEOUT_ADDR;
  wire mapped = sel_cfg | sel_cmd | sel_ref | sel_wbto;
  wire setup = psel_i & ~penable_i;
  wire access = psel_i & penable_i;
  wire wr = access & pwrite_i & mapped;
  wire rd_setup = setup & ~pwrite_i;

  wire [31:0] cfg_word = {{(32-CFG_BITS){1'b0}}, cfg};
  wire [31:0] cmd_word = {{(32-BUSY_BIT-1){1'b0}}, busy_o, wbuf_en,
                          init_mode};
  wire [31:0] ref_word = {{(32-REF_BITS){1'b0}}, refresh_period};
  wire [31:0] wbto_word = {{(32-WBTO_BITS){1'b0}}, write_buffer_timeout};
  wire [31:0] cfg_merge = wmerge(cfg_word, pwdata_i, pstrb_i);
  wire [31:0] cmd_merge = wmerge(cmd_word, pwdata_i, pstrb_i);
  wire [31:0] ref_merge = wmerge(ref_word, pwdata_i, pstrb_i);
  wire [31:0] wbto_merge = wmerge(wbto_word, pwdata_i, pstrb_i);
  wire [31:0] read_mux = sel_cfg ? cfg_word :
                         sel_cmd ? cmd_word :
                         sel_ref ? ref_word :
                         sel_wbto ? wbto_word : 32'h00000000;
  wire init_write = wr & sel_cmd & pstrb_i[0];
  wire [INIT_BITS-1:0] init_new = cmd_merge[INIT_LSB +: INIT_BITS];

  assign pready_o = 1'b1;
  assign pslverr_o = access & ~mapped;

  // register writes take effect in the access phase
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cfg <= sdram_cfg_s'(SDRAM_CONFIG_RESET[CFG_BITS-1:0]);
    end else if (wr & sel_cfg) begin
      cfg <= sdram_cfg_s'(cfg_merge[CFG_BITS-1:0]);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      init_mode <= SDRAM_COMMAND_RESET[INIT_LSB +: INIT_BITS];
      wbuf_en <= SDRAM_COMMAND_RESET[WBUF_BIT];
    end else if (wr & sel_cmd) begin
      init_mode <= init_new;
      wbuf_en <= cmd_merge[WBUF_BIT];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      refresh_period <= REFRESH_PERIOD_RESET[REF_BITS-1:0];
      write_buffer_timeout <= WB_TIMEOUT_RESET[WBTO_BITS-1:0];
    end else begin
      if (wr & sel_ref) begin
        refresh_period <= ref_merge[REF_BITS-1:0];
      end
      if (wr & sel_wbto) begin
        write_buffer_timeout <= wbto_merge[WBTO_BITS-1:0];
      end
    end
  end

  // read data is captured in the setup phase so it leaves a flop
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      prdata_o <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_o <= read_mux;
    end
  end

  // interval checks: a counter at zero means the wait is over
  wire act_ok = (tcnt[T_RC] == 4'h0) & (tcnt[T_RP] == 4'h0) & ~row_open;
  wire col_ok = (tcnt[T_RCD] == 4'h0) & row_open;
  wire pre_ok = tcnt[T_RAS] == 4'h0;
  wire run = (state == ST_RUN) & (init_mode == INIT_NORMAL);
  wire ap_on = ~cfg.auto_precharge_disable;

  always_comb begin
    req_ready_o = 1'b0;
    if (run) begin
      case (req_kind_i)
        CMD_ACT: req_ready_o = act_ok;
        CMD_COL: req_ready_o = col_ok;
        CMD_PRE: req_ready_o = pre_ok;
        default: req_ready_o = 1'b1;
      endcase
    end
  end

  wire fire = req_valid_i & req_ready_o;
  wire pall_fire = (state == ST_PALL) & pre_ok;
  wire mrs_fire = (state == ST_MRS) & act_ok;
  wire issue_act = fire & (req_kind_i == CMD_ACT);
  wire issue_col = fire & (req_kind_i == CMD_COL);
  wire issue_pre = (fire & (req_kind_i == CMD_PRE)) | pall_fire;
  wire row_close = issue_pre | (issue_col & ap_on);

  always_comb begin
    next_cmd = '{valid: 1'b0, kind: CMD_NOP, auto_pre: 1'b0};
    if (pall_fire) begin
      next_cmd = '{valid: 1'b1, kind: CMD_PALL, auto_pre: 1'b1};
    end else if (mrs_fire) begin
      next_cmd = '{valid: 1'b1, kind: CMD_MRS, auto_pre: 1'b0};
    end else if (issue_act | issue_col | issue_pre) begin
      next_cmd = '{valid: 1'b1, kind: req_kind_i,
                   auto_pre: issue_col & ap_on};
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (init_write & (init_new == INIT_PALL)) begin
          next_state = ST_PALL;
        end else if (init_write & (init_new == INIT_MRS)) begin
          next_state = ST_MRS;
        end
      end
      ST_PALL: next_state = pall_fire ? ST_RUN : ST_PALL;
      ST_MRS: next_state = mrs_fire ? ST_RUN : ST_MRS;
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= ST_RUN;
      cmd_o <= '{valid: 1'b0, kind: CMD_NOP, auto_pre: 1'b0};
      row_open <= 1'b0;
    end else begin
      state <= next_state;
      cmd_o <= next_cmd;
      if (issue_act) begin
        row_open <= 1'b1;
      end else if (row_close) begin
        row_open <= 1'b0;
      end
    end
  end

  // interval counters, loaded with the code so the gap is code plus one
  assign tload[T_RCD] = {2'h0, cfg.row_to_column_delay};
  assign tload[T_RAS] = cfg.row_active_time;
  assign tload[T_RC] = cfg.row_cycle_time;
  assign tload[T_RP] = {2'h0, cfg.precharge_time};
  assign tstart = {row_close, issue_act, issue_act, issue_act};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TCNT; gi++) begin : g_tcnt
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          tcnt[gi] <= 4'h0;
        end else if (tstart[gi]) begin
          tcnt[gi] <= tload[gi];
        end else if (tcnt[gi] != 4'h0) begin
          tcnt[gi] <= tcnt[gi] - 4'h1;
        end
      end
    end
  endgenerate

  wire cnt_active = (tcnt[T_RCD] != 4'h0) | (tcnt[T_RAS] != 4'h0) |
                    (tcnt[T_RC] != 4'h0) | (tcnt[T_RP] != 4'h0);
  assign busy_o = (state != ST_RUN) | cnt_active | cmd_o.valid;

  assign cfg_o = cfg;
  assign write_buffer_enable_o = wbuf_en;
  assign refresh_period_o = refresh_period;
  assign wb_timeout_o = write_buffer_timeout;

  // cycles since the last issued activate and precharge, saturating
  logic [4:0] since_act;
  logic [4:0] since_pre;
  wire out_act = cmd_o.valid & (cmd_o.kind == CMD_ACT);
  wire out_col = cmd_o.valid & (cmd_o.kind == CMD_COL);
  wire out_pre = cmd_o.valid &
                 ((cmd_o.kind == CMD_PRE) | (cmd_o.kind == CMD_PALL) |
                  ((cmd_o.kind == CMD_COL) & cmd_o.auto_pre));

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      since_act <= 5'h1F;
      since_pre <= 5'h1F;
    end else begin
      since_act <= out_act ? 5'h01 :
                   (since_act == 5'h1F) ? since_act : since_act + 5'h01;
      since_pre <= out_pre ? 5'h01 :
                   (since_pre == 5'h1F) ? since_pre : since_pre + 5'h01;
    end
  end

  sequence s_cfg_write_lane0;
    access & pwrite_i & sel_cfg & pstrb_i[0];
  endsequence

  sequence s_act_out;
    cmd_o.valid && (cmd_o.kind == CMD_ACT);
  endsequence

  sequence s_cfg_write_lane1;
    access & pwrite_i & sel_cfg & pstrb_i[1];
  endsequence

  sequence s_cfg_write_lane2;
    access & pwrite_i & sel_cfg & pstrb_i[2];
  endsequence

  a_width_write: assert property (
    @(posedge clock_i) disable iff (rst_i)
    s_cfg_write_lane0 |=> cfg_o.bus_width_sel == $past(pwdata_i[0]))
    else $error("bus width bit did not take written value");

  a_auto_pre_col: assert property (
    @(posedge clock_i) disable iff (rst_i)
    out_col |-> cmd_o.auto_pre == !$past(cfg.auto_precharge_disable))
    else $error("column auto precharge disagrees with policy bit");

  a_cl_reset: assert property (
    @(posedge clock_i)
    rst_i |=> cfg_o.cas_latency == 2'h3 && cfg_o.bus_width_sel == 1'b0)
    else $error("cas latency not three after reset");

  a_density_reset: assert property (
    @(posedge clock_i)
    rst_i |=> cfg_o.bank_group_one_density == 2'h0 &&
              cfg_o.bank_group_zero_density == 2'h0)
    else $error("bank densities not zero after reset");

  a_rp_gap: assert property (
    @(posedge clock_i) disable iff (rst_i)
    s_act_out |-> since_pre >= 5'({3'h0, $past(cfg.precharge_time)} + 5'h1))
    else $error("activate too soon after precharge");

  a_rcd_gap: assert property (
    @(posedge clock_i) disable iff (rst_i)
    out_col |-> since_act >=
      5'({3'h0, $past(cfg.row_to_column_delay)} + 5'h1))
    else $error("column command too soon after activate");

  a_rc_gap: assert property (
    @(posedge clock_i) disable iff (rst_i)
    s_act_out |-> since_act >= 5'({1'b0, $past(cfg.row_cycle_time)} + 5'h1))
    else $error("activate too soon after activate");

  a_ras_gap: assert property (
    @(posedge clock_i) disable iff (rst_i)
    out_pre && !cmd_o.auto_pre || cmd_o.valid && cmd_o.kind == CMD_PALL
    |-> since_act >= 5'({1'b0, $past(cfg.row_active_time)} + 5'h1))
    else $error("precharge too soon after activate");

  a_busy_read: assert property (
    @(posedge clock_i) disable iff (rst_i)
    rd_setup && sel_cmd |=> prdata_o[BUSY_BIT] == $past(busy_o))
    else $error("busy bit read back wrong");

  a_busy_after_act: assert property (
    @(posedge clock_i) disable iff (rst_i)
    issue_act && cfg.row_cycle_time > 4'h1 |=> busy_o [*2])
    else $error("engine not busy after activate");

  // lane 0 carries policy, latency and density fields
  a_low_fields_write: assert property (
    @(posedge clock_i) disable iff (rst_i)
    s_cfg_write_lane0 |=> cfg_o[7:1] == $past(pwdata_i[7:1]))
    else $error("low config fields did not take written value");

  a_row_fields_write: assert property (
    @(posedge clock_i) disable iff (rst_i)
    s_cfg_write_lane1 |=> cfg_o[15:8] == $past(pwdata_i[15:8]))
    else $error("row timing fields did not take written value");

  a_ras_field_write: assert property (
    @(posedge clock_i) disable iff (rst_i)
    s_cfg_write_lane2 |=> cfg_o.row_active_time == $past(pwdata_i[19:16]))
    else $error("row active field did not take written value");

endmodule

// ### sdram_model.sv
// Purpose: far-side device model that watches issued commands for spacing
// Assumes: one open row at a time, commands arrive as cmd_s pulses
// Notes: viol_o counts commands placed closer than the configured gaps
`timescale 1ns/1ps
module sdram_model
  import sdram_cfg_pkg::*;
(
  input wire logic clock_i,
  input wire cmd_s cmd_i,
  input wire sdram_cfg_s cfg_i,
  output int viol_o
);
  int cyc = 0;
  int t_act = -99;
  int t_pre = -99;
  logic row_open = 1'b0;
  int viol = 0;
  assign viol_o = viol;
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cmd_i.valid === 1'b1) begin
      case (cmd_i.kind)
        CMD_ACT: begin
          if (row_open || cyc - t_act <= cfg_i.row_cycle_time ||
              cyc - t_pre <= cfg_i.precharge_time)
            viol <= viol + 1;
          t_act <= cyc;
          row_open <= 1'b1;
        end
        CMD_COL: begin
          if (!row_open || cyc - t_act <= cfg_i.row_to_column_delay)
            viol <= viol + 1;
          if (cmd_i.auto_pre) begin
            row_open <= 1'b0;
            t_pre <= cyc;
          end
        end
        CMD_PRE: begin
          if (cyc - t_act <= cfg_i.row_active_time)
            viol <= viol + 1;
          row_open <= 1'b0;
          t_pre <= cyc;
        end
        default: ;
      endcase
    end
  end
endmodule

// ### tb.sv
// Purpose: self-checking bench of the sdram timing configuration
// Assumes: zero-wait apb slave, one clock, results noted in queues
// Notes: monitors pop the oldest note when a read or a command appears
`timescale 1ns/1ps
module tb;
  import sdram_cfg_pkg::*;
  logic clock_i = 0, rst_i = 1, psel = 0, pen = 0, pwr = 0, rv = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic [3:0] pstrb = 0;
  cmd_kind_e rk = CMD_NOP;
  logic pready, pslverr, rready, busy, wbe;
  cmd_s cmd;
  sdram_cfg_s cfg;
  logic [15:0] refp, wbto;
  int num_errors = 0, n_tests = 0, cyc = 0, viol;
  int seed = 32'h936FCF2B;
  logic [32:0] rq[$];
  logic [3:0] cq[$];
  int tq[$];
  always #2 clock_i = ~clock_i;
  sdram_timing_config uut (
    .clock_i(clock_i), .rst_i(rst_i), .paddr_i(paddr), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .req_valid_i(rv), .req_kind_i(rk), .req_ready_o(rready),
    .cmd_o(cmd), .cfg_o(cfg), .write_buffer_enable_o(wbe),
    .refresh_period_o(refp), .wb_timeout_o(wbto), .busy_o(busy));
  sdram_model mem (.clock_i(clock_i), .cmd_i(cmd), .cfg_i(cfg),
    .viol_o(viol));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_cmd(input logic [3:0] got, input logic [3:0] exp);
    cmp({29'h0, got}, {29'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clock_i);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock_i);
    pen <= 1;
    do @(posedge clock_i); while (pready !== 1'b1 && n++ < 50);
    cmp({32'h0, pready}, 33'h1);
    psel <= 0;
    pen <= 0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    apb(1'b1, a, d, s);
  endtask
  task automatic rd(input logic [31:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask
  task automatic req(input cmd_kind_e k, input logic auto_pre);
    int n;
    n = 0;
    cq.push_back({k, auto_pre});
    rv <= 1;
    rk <= k;
    do @(negedge clock_i); while (rready !== 1'b1 && n++ < 200);
    @(posedge clock_i);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do @(negedge clock_i); while (busy !== 1'b0 && n++ < 200);
    cmp({32'h0, busy}, 33'h0);
  endtask
  function automatic int mx(input int a, input int b);
    return a > b ? a : b;
  endfunction
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
    if (psel && pen && !pwr && pready === 1'b1)
      cmp({pslverr, prdata}, rq.size() ? rq.pop_front() : 33'h1FFFFFFFF);
    if (cmd.valid === 1'b1) begin
      cmp_cmd({cmd.kind, cmd.kind == CMD_COL ? cmd.auto_pre : 1'b0},
              cq.size() ? cq.pop_front() : 4'hF);
      tq.push_back(cyc);
    end
  end
  initial begin
    logic [31:0] d, sh;
    logic [3:0] s, cyc_gap, act_gap;
    logic [1:0] act_col, pre_gap;
    logic keep_open;
    int t0, t_close, t_act2;
    sh = SDRAM_CONFIG_RESET;
    repeat (2) @(posedge clock_i);
    rst_i <= 0;
    cmp({13'h0, cfg}, {1'b0, sh});
    rd(SDRAM_CONFIG_ADDR, {1'b0, sh});
    rd(SDRAM_COMMAND_ADDR, 33'h0);
    rd(REFRESH_PERIOD_ADDR, 33'h20);
    rd(WB_TIMEOUT_ADDR, 33'h0);
    wr(32'hF0020010, 32'hFFFFFFFF, 4'hF);
    rd(32'hF0020010, {1'b1, 32'h0});
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      s = 4'($random(seed));
      wr(SDRAM_CONFIG_ADDR, d, s);
      for (int b = 0; b < 4; b++) if (s[b]) sh[8*b+:8] = d[8*b+:8];
      sh &= 32'h000FFFFF;
      rd(SDRAM_CONFIG_ADDR, {1'b0, sh});
      cmp({13'h0, cfg}, {1'b0, sh});
      wr(REFRESH_PERIOD_ADDR, d, 4'hF);
      rd(REFRESH_PERIOD_ADDR, {17'h0, d[15:0]});
      cmp({17'h0, refp}, {17'h0, d[15:0]});
      wr(WB_TIMEOUT_ADDR, ~d, 4'hF);
      rd(WB_TIMEOUT_ADDR, {17'h0, ~d[15:0]});
      cmp({17'h0, wbto}, {17'h0, ~d[15:0]});
    end
    wr(SDRAM_COMMAND_ADDR, 32'hFFFFFFFC, 4'hF);
    rd(SDRAM_COMMAND_ADDR, 33'h4);
    cmp({32'h0, wbe}, 33'h1);
    rk <= CMD_ACT;
    cq.push_back({CMD_PALL, 1'b0});
    wr(SDRAM_COMMAND_ADDR, 32'h5, 4'hF);
    @(negedge clock_i);
    cmp({32'h0, rready}, 33'h0);
    wait_idle();
    wr(SDRAM_COMMAND_ADDR, 32'h4, 4'hF);
    cq.push_back({CMD_MRS, 1'b0});
    wr(SDRAM_COMMAND_ADDR, 32'h6, 4'hF);
    wait_idle();
    wr(SDRAM_COMMAND_ADDR, 32'h4, 4'hF);
    wr(SDRAM_CONFIG_ADDR, 32'h000FF00C, 4'hF);
    req(CMD_ACT, 1'b0);
    rv <= 0;
    rd(SDRAM_COMMAND_ADDR, 33'hC);
    req(CMD_PRE, 1'b0);
    rv <= 0;
    for (int i = 0; i < 4; i++) begin
      act_col = 2'($random(seed));
      pre_gap = 2'($random(seed));
      cyc_gap = 4'($random(seed));
      act_gap = 4'($random(seed));
      keep_open = i[0];
      wait_idle();
      wr(SDRAM_CONFIG_ADDR, {12'h0, act_gap, cyc_gap, act_col, pre_gap,
         6'h03, keep_open, i[1]}, 4'hF);
      tq.delete();
      req(CMD_ACT, 1'b0);
      cmp({32'h0, cfg.bus_width_sel}, {32'h0, i[1]});
      req(CMD_COL, !keep_open);
      if (keep_open) req(CMD_PRE, 1'b0);
      req(CMD_ACT, 1'b0);
      req(CMD_PRE, 1'b0);
      rv <= 0;
      repeat (3) @(posedge clock_i);
      t0 = tq[0];
      cmp(33'(tq[1]), 33'(t0 + act_col + 1));
      t_close = keep_open ? tq[2] : tq[1];
      if (keep_open)
        cmp(33'(tq[2]), 33'(mx(t0 + act_gap + 1, tq[1] + 1)));
      t_act2 = tq[keep_open ? 3 : 2];
      cmp(33'(t_act2),
          33'(mx(t0 + cyc_gap + 1, t_close + pre_gap + 1)));
      cmp(33'(tq[keep_open ? 4 : 3]), 33'(t_act2 + act_gap + 1));
    end
    wait_idle();
    cmp(33'(viol), 33'h0);
    cmp(33'(rq.size() + cq.size()), 33'h0);
    report_and_stop();
  end
endmodule
